// *** include/psic_pkg.sv ***
// Shared constants and types for the serial interrupt control block.
// Assumes a 200 MHz system clock; serial link clocked by its own clock pin.
package psic_pkg;

  // ****************************************************************
  // Clock and debounce timing
  // ****************************************************************
  localparam int  SYS_CLK_MHZ    = 200;         // System clock rate
  localparam real DBNC_MID_MS    = 3.9;         // Supply and thermal events
  localparam real DBNC_SLOW_MS   = 31.25;       // Button events
  localparam real DBNC_FAULT_MS  = 8.0;         // Overcurrent and fuse error
  localparam int  DBNC_MID_CYC   = int'($ceil(DBNC_MID_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int  DBNC_SLOW_CYC  = int'($ceil(DBNC_SLOW_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int  DBNC_FAULT_CYC = int'($ceil(DBNC_FAULT_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int  DBNC_CNT_W     = 26;          // Holds slowest time shifted by 3
  localparam int  PRIME_W        = 3;           // Settling count width; primed 7 cycles after reset

  // ****************************************************************
  // Register map: four banks of flags, masks, live state
  // ****************************************************************
  localparam int         NUM_BANKS = 4;
  localparam logic [7:0] BANK_BASE [NUM_BANKS] = '{8'h05, 8'h08, 8'h0E, 8'h11};
  localparam logic [1:0] KIND_FLAGS = 2'h0;     // Sticky flags, write one to clear
  localparam logic [1:0] KIND_MASKS = 2'h1;     // Mask bits, read and write
  localparam logic [1:0] KIND_LIVE  = 2'h2;     // Live source state, read only

  // Source positions: byte b of the vector is bank b
  localparam logic [31:0] SRC_USED = 32'h3F817F3F; // Implemented bits
  localparam logic [31:0] SRC_RISE = 32'h3F817F3D; // Events on rising input
  localparam logic [31:0] SRC_FALL = 32'h0000003F; // Events on falling input
  localparam logic [31:0] SRC_EXT  = 32'h00000003; // Falling time extendable
  localparam logic [31:0] SRC_SLOW = 32'h00000001; // Button debounce class
  localparam logic [31:0] SRC_MID  = 32'h0000003E; // Supply/thermal class
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = SRC_USED;   // All interrupts masked

  // ****************************************************************
  // Serial target constants
  // ****************************************************************
  localparam int         ADDR_SEL_W  = 3;         // Fuse-set low address bits
  localparam logic [6:0] GCALL_ADDR  = 7'h00;     // General call, never answered
  localparam logic [3:0] ACK_SLOT    = 4'h8;      // Bit count of the ack clock
  localparam logic [3:0] LAST_BIT    = 4'h7;      // Bit count of eighth data bit

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;                             // Register index
    logic [7:0] data;                             // Byte written
  } psic_wr_t;

  typedef struct packed {
    logic                  scl;                   // Link clock level
    logic                  sda;                   // Link data level
    logic [ADDR_SEL_W-1:0] sel;                   // Address select bits
    logic [1:0]            dbsel;                 // Button debounce select
    logic                  wr_tog;                // Write toggle from link
    logic [7:0]            ptr;                   // Register pointer from link
    logic [31:0]           src;                   // Event sources
  } psic_async_t;

  localparam int ASYNC_W = $bits(psic_async_t);
  localparam logic [ASYNC_W-1:0] ASYNC_RESET = {2'b11, {(ASYNC_W-2){1'b0}}};

  typedef struct packed {
    logic       hit;                              // Address is mapped
    logic [1:0] bank;                             // Bank index
    logic [1:0] kind;                             // Flags, masks or live
  } psic_dec_t;

  typedef enum logic [4:0] {
    LS_ADDR  = 5'b00001,                          // Receiving target address
    LS_REG   = 5'b00010,                          // Receiving register index
    LS_WDATA = 5'b00100,                          // Receiving write data
    LS_RDATA = 5'b01000,                          // Sending read data
    LS_SKIP  = 5'b10000                           // Not addressed or done
  } psic_link_st_t;

endpackage

// *** core/psic_top.sv ***
// Serial target port and latched, maskable interrupt unit.
// Assumes sys_clk_i far faster than the link clock and pins from outside.
//
// Notes on behaviour
// [RULE1] Seven-bit addressing only, no general call
// [RULE2] Low three address bits from fuse setting
// [RULE3] New address select applies immediately
// [RULE4] Fast-mode operation up to 400 kbit/s
// [RULE5] Read bytes sent MSB first, ack after
// [RULE6] Read until host NACK or STOP
// [RULE7] Answer only own target address
// [RULE8] Host retries whole transaction after NACK
// [RULE9] Interrupt low while unmasked flag pending
// [RULE10] Flags latch until software clears them
// [RULE11] Write one clears flag, zero keeps
// [RULE12] New event during clear keeps interrupt low
// [RULE13] Mask blocks interrupt, flag still readable
// [RULE14] All masks set after reset
// [RULE15] Unmasking a set flag asserts interrupt
// [RULE16] Live state read only, not latched
// [RULE17] Supply falling, thermal both edges, debounced
// [RULE18] Button both edges after stable debounce
// [RULE19] Overcurrent and fuse error rising, debounced
// [RULE20] Button and supply falling time extendable
// [RULE21] Bank zero flags: button, supply, thermals
// [RULE22] Bank zero masks same order, reset one
// [RULE23] Interrupt is OR of flag and not mask
`timescale 1ns/1ps
module psic_top
  import psic_pkg::*;
#(
  parameter logic [3:0] TARGET_ADDR_HIGH = 4'h5,          // Upper address bits
  parameter int         DBNC_MID_CYCLES  = DBNC_MID_CYC,  // Supply/thermal time
  parameter int         DBNC_SLOW_CYCLES = DBNC_SLOW_CYC, // Button time
  parameter int         DBNC_FAULT_CYCLES = DBNC_FAULT_CYC // Fault time
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  scl_clk_i,
  input  wire logic                  sda_i,
  output wire logic                  sda_o,
  output wire logic                  sda_oe_o,
  output wire logic                  irq_out_n_o,
  output wire logic                  irq_oe_o,
  input  wire logic                  power_button_in_i,
  input  wire logic                  low_supply_in_i,
  input  wire logic [3:0]            temp_level_in_i,
  input  wire logic [6:0]            buck_overcurrent_in_i,
  input  wire logic                  boost_overcurrent_in_i,
  input  wire logic                  fuse_memory_error_in_i,
  input  wire logic [5:0]            ldo_overcurrent_in_i,
  input  wire logic [ADDR_SEL_W-1:0] target_addr_select_bits_i,
  input  wire logic [1:0]            button_debounce_select_i
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [ASYNC_W-1:0] sync1_reg;          // First synchroniser stage
  logic [ASYNC_W-1:0] sync2_reg;          // Second stage
  logic [ASYNC_W-1:0] sync3_reg;          // Third stage
  logic [ASYNC_W-1:0] filt_reg;           // Accepted input levels
  logic [ASYNC_W-1:0] filt_next;
  psic_async_t        async_raw;          // Inputs before crossing
  psic_async_t        view;               // Accepted inputs, by field
  logic               sda_prev_reg;       // Data level one cycle back
  logic               link_hold_reg;      // Holds link logic cleared
  logic               in_frame_reg;       // A START has been seen
  logic               tog_seen_reg;       // Last write toggle consumed
  logic [PRIME_W-1:0] prime_cnt_reg;      // Settling after reset
  logic [31:0]        flags_reg;          // Sticky event flags
  logic [31:0]        flags_next;
  logic [31:0]        mask_reg;           // Interrupt masks
  logic [31:0]        mask_next;
  logic               irq_n_reg;          // Interrupt pin level
  logic [7:0]         rd_data_reg;        // Byte for the link to send
  wire  [31:0]        evt_vec;            // Debounced event pulses
  // Link-clock domain
  psic_link_st_t      st_reg;             // Link state
  logic [3:0]         bit_cnt_reg;        // Bit within byte, 8 is ack
  logic [7:0]         shift_reg;          // Received bits
  logic               ack_reg;            // Drive ack in next slot
  logic [7:0]         ptr_reg;            // Register pointer
  logic               wr_tog_reg;         // Flips on each write byte
  psic_wr_t           wr_pkt_reg;         // Last write byte and index
  logic [7:0]         tx_reg;             // Byte being sent
  logic               sda_oe_reg;         // Pulling data low

  // ****************************************************************
  // Decoding helper
  // ****************************************************************
  // Maps a register index to bank and kind
  function automatic psic_dec_t reg_decode(input logic [7:0] a);
    psic_dec_t  d;
    logic [7:0] off;
    d = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      off = a - BANK_BASE[b];
      if (off <= 8'(KIND_LIVE)) begin
        d.hit  = 1'b1;
        d.bank = 2'(b);
        d.kind = off[1:0];
      end
    end
    return d;
  endfunction

  // ****************************************************************
  // Input gathering and synchronisers
  // ****************************************************************
  assign async_raw.scl    = scl_clk_i;
  assign async_raw.sda    = sda_i;
  assign async_raw.sel    = target_addr_select_bits_i;
  assign async_raw.dbsel  = button_debounce_select_i;
  assign async_raw.wr_tog = wr_tog_reg;
  assign async_raw.ptr    = ptr_reg;
  assign async_raw.src    = {2'b00, ldo_overcurrent_in_i, fuse_memory_error_in_i, 6'h00,
                             boost_overcurrent_in_i, 1'b0, buck_overcurrent_in_i, 2'b00,
                             temp_level_in_i, low_supply_in_i, power_button_in_i};

  // A bit changes once stages two and three agree
  assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
  assign view      = psic_async_t'(filt_reg);

  // Three-stage crossing of every outside input
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= ASYNC_RESET;
      sync2_reg <= ASYNC_RESET;
      sync3_reg <= ASYNC_RESET;
      filt_reg  <= ASYNC_RESET;
    end else begin
      sync1_reg <= async_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  // ****************************************************************
  // START and STOP detection
  // ****************************************************************
  wire start_seen = view.scl & sda_prev_reg & ~view.sda;  // Data falls, clock high
  wire stop_seen  = view.scl & ~sda_prev_reg & view.sda;  // Data rises, clock high

  // Hold link logic cleared from START until clock low, and after STOP
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_prev_reg  <= 1'b1;
      link_hold_reg <= 1'b1;
      in_frame_reg  <= 1'b0;
    end else begin
      sda_prev_reg <= view.sda;
      if (start_seen) begin
        link_hold_reg <= 1'b1;
        in_frame_reg  <= 1'b1;
      end else if (stop_seen) begin        // Stop also ends any read [RULE6]
        link_hold_reg <= 1'b1;
        in_frame_reg  <= 1'b0;
      end else if (in_frame_reg && !view.scl) begin
        link_hold_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register access from the link
  // ****************************************************************
  // Write packet is stable for a whole byte time once the toggle moves
  wire        wr_fire   = view.wr_tog ^ tog_seen_reg;
  psic_dec_t  wr_dec;
  psic_dec_t  rd_dec;
  wire [4:0]  wr_sh     = {wr_dec.bank, 3'b000};
  wire [4:0]  rd_sh     = {rd_dec.bank, 3'b000};
  wire [31:0] wr_byte_v = 32'(wr_pkt_reg.data) << wr_sh;
  assign wr_dec = reg_decode(wr_pkt_reg.addr);
  assign rd_dec = reg_decode(view.ptr);

  wire        flag_hit = wr_fire && wr_dec.hit && (wr_dec.kind == KIND_FLAGS);
  wire        mask_hit = wr_fire && wr_dec.hit && (wr_dec.kind == KIND_MASKS);
  wire [31:0] clr_vec  = flag_hit ? wr_byte_v : 32'h00000000;   // [RULE11]
  wire [31:0] live_vec = view.src & SRC_USED;                   // [RULE16]
  wire [31:0] pending  = flags_reg & ~mask_reg;                 // [RULE23]

  // Set wins over a clear in the same cycle
  assign flags_next = ((flags_reg & ~clr_vec) | evt_vec) & SRC_USED; // [RULE10] [RULE12]
  // Writes to live state change nothing; masks keep implemented bits only
  assign mask_next  = mask_hit ? (((mask_reg & ~(32'h000000FF << wr_sh)) | wr_byte_v) & SRC_USED)
                               : mask_reg;                      // [RULE13] [RULE22]

  // Read selection for the current pointer; unmapped reads give zero
  wire [31:0] rd_vec  = (rd_dec.kind == KIND_FLAGS) ? flags_reg :
                        (rd_dec.kind == KIND_MASKS) ? mask_reg  : live_vec;
  wire [7:0]  rd_byte = rd_dec.hit ? 8'(rd_vec >> rd_sh) : 8'h00;  // [RULE21]

  // Flags, masks, interrupt pin and read byte
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_seen_reg  <= 1'b0;
      prime_cnt_reg <= '0;
      flags_reg     <= FLAG_RESET;
      mask_reg      <= MASK_RESET;         // [RULE14]
      irq_n_reg     <= 1'b1;
      rd_data_reg   <= 8'h00;
    end else begin
      tog_seen_reg  <= view.wr_tog;
      prime_cnt_reg <= (&prime_cnt_reg) ? prime_cnt_reg : prime_cnt_reg + 1'b1;
      flags_reg     <= flags_next;
      mask_reg      <= mask_next;
      irq_n_reg     <= ~|pending;          // [RULE9] [RULE15]
      rd_data_reg   <= rd_byte;
    end
  end

  // Open-drain interrupt: pulled low only while asserted
  assign irq_out_n_o = irq_n_reg;
  assign irq_oe_o    = ~irq_n_reg;

  // ****************************************************************
  // Debounce of each event source
  // ****************************************************************
  wire primed = &prime_cnt_reg;          // Inputs have settled after reset

  generate
    for (genvar i = 0; i < 32; i++) begin : g_src
      if (SRC_USED[i]) begin : g_used
        logic                  stable_reg;   // Debounced level
        logic [DBNC_CNT_W-1:0] cnt_reg;      // Cycles of disagreement
        wire  [DBNC_CNT_W-1:0] base_lim = SRC_SLOW[i] ? DBNC_CNT_W'(DBNC_SLOW_CYCLES) :
                                          SRC_MID[i]  ? DBNC_CNT_W'(DBNC_MID_CYCLES)  :
                                                        DBNC_CNT_W'(DBNC_FAULT_CYCLES);
        // Falling time stretched by the select field [RULE20]
        wire  [DBNC_CNT_W-1:0] fall_lim = SRC_EXT[i] ? (base_lim << view.dbsel) : base_lim;
        wire  [DBNC_CNT_W-1:0] lim      = stable_reg ? fall_lim : base_lim;
        wire                   live     = view.src[i];
        wire                   differ   = live ^ stable_reg;
        wire                   done     = differ && (cnt_reg == lim - 1'b1);
        // Edge filters per source [RULE17] [RULE18] [RULE19]
        assign evt_vec[i] = primed && done && (live ? SRC_RISE[i] : SRC_FALL[i]);

        // Count stable disagreement, then take the new level
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
          if (rst_i) begin
            stable_reg <= 1'b0;
            cnt_reg    <= '0;
          end else if (!primed) begin
            stable_reg <= live;              // Adopt power-up level silently
            cnt_reg    <= '0;
          end else begin
            stable_reg <= done ? live : stable_reg;
            cnt_reg    <= (differ && !done) ? cnt_reg + 1'b1 : '0;
          end
        end
      end else begin : g_none
        assign evt_vec[i] = 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // Link-clock domain: serial target
  // ****************************************************************
  // Data sampled on rising clock, driven after falling clock; bit
  // periods down to fast-mode rates leave the crossings many
  // system cycles of margin [RULE4]
  wire [7:0] rx_byte  = {shift_reg[6:0], sda_i};
  // Address select read live, so a rewrite counts at once [RULE2] [RULE3]
  wire [6:0] own_addr = {TARGET_ADDR_HIGH, view.sel};
  wire       addr_hit = (rx_byte[7:1] == own_addr) && (rx_byte[7:1] != GCALL_ADDR); // [RULE1] [RULE7]

  // Bit counting, acknowledge decision and transaction state
  always_ff @(posedge scl_clk_i or posedge link_hold_reg) begin
    if (link_hold_reg) begin
      st_reg      <= LS_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ack_reg     <= 1'b0;
    end else if (bit_cnt_reg != ACK_SLOT) begin
      shift_reg   <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == LAST_BIT) begin
        ack_reg <= (st_reg == LS_ADDR) ? addr_hit :
                   ((st_reg == LS_REG) || (st_reg == LS_WDATA));  // [RULE7]
      end
    end else begin
      bit_cnt_reg <= 4'h0;
      ack_reg     <= 1'b0;
      unique case (st_reg)
        LS_ADDR:  st_reg <= !ack_reg ? LS_SKIP : (shift_reg[0] ? LS_RDATA : LS_REG);
        LS_REG:   st_reg <= LS_WDATA;
        LS_WDATA: st_reg <= LS_WDATA;
        LS_RDATA: st_reg <= sda_i ? LS_SKIP : LS_RDATA;         // Host NACK ends it [RULE6]
        LS_SKIP:  st_reg <= LS_SKIP;
      endcase
    end
  end

  // Pointer and write hand-off survive repeated START
  always_ff @(posedge scl_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg    <= 8'h00;
      wr_tog_reg <= 1'b0;
      wr_pkt_reg <= '0;
    end else if (!link_hold_reg) begin
      if (bit_cnt_reg == LAST_BIT && st_reg == LS_REG) begin
        ptr_reg <= rx_byte;
      end else if (bit_cnt_reg == LAST_BIT && st_reg == LS_WDATA) begin
        wr_pkt_reg <= '{addr: ptr_reg, data: rx_byte};
        wr_tog_reg <= ~wr_tog_reg;
        ptr_reg    <= ptr_reg + 1'b1;
      end else if (bit_cnt_reg == ACK_SLOT && st_reg == LS_RDATA) begin
        ptr_reg <= ptr_reg + 1'b1;
      end
    end
  end

  // Data line drive, changed only while the clock is low
  always_ff @(negedge scl_clk_i or posedge link_hold_reg) begin
    if (link_hold_reg) begin
      sda_oe_reg <= 1'b0;
      tx_reg     <= 8'h00;
    end else if (bit_cnt_reg == ACK_SLOT) begin
      sda_oe_reg <= ack_reg;                  // Ack, or release for host
    end else if (st_reg == LS_RDATA) begin
      if (bit_cnt_reg == 4'h0) begin
        tx_reg     <= rd_data_reg;             // Byte ready well before use
        sda_oe_reg <= ~rd_data_reg[7];         // [RULE5]
      end else begin
        sda_oe_reg <= ~tx_reg[3'(LAST_BIT - bit_cnt_reg)];  // [RULE5]
      end
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE9]
    (pending != 32'h0) |=> !irq_out_n_o)
    else $error("pending unmasked flag but interrupt high");

  a_irq_release: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE11]
    (flag_hit && ((flags_reg & ~mask_reg & ~clr_vec) == 32'h0) && (evt_vec == 32'h0))
      |=> ##1 ((evt_vec != 32'h0) || $past(evt_vec) != 32'h0 || irq_out_n_o))
    else $error("interrupt not released after last flag cleared");

  a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE10]
    ##1 ((($past(flags_reg) & ~$past(clr_vec)) & ~flags_reg) == 32'h0))
    else $error("flag dropped without a clear");

  a_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE12]
    (evt_vec != 32'h0) |=> ((flags_reg & $past(evt_vec)) == $past(evt_vec)))
    else $error("event lost against clear");

  a_w1c_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE11]
    (flag_hit && (evt_vec == 32'h0)) |=> ((flags_reg & $past(clr_vec)) == 32'h0))
    else $error("write one did not clear flag");

  a_mask_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE14]
    (prime_cnt_reg == 3'h0) |-> (mask_reg == MASK_RESET))
    else $error("masks not all set after reset");

  a_unmask_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE15]
    (mask_hit && ((flags_reg & ~mask_next) != 32'h0)) |-> ##2 !irq_out_n_o)
    else $error("unmasked pending flag did not assert interrupt");

  a_addr_ignore: assert property (@(posedge scl_clk_i) disable iff (link_hold_reg) // [RULE1]
    (st_reg == LS_ADDR && bit_cnt_reg == LAST_BIT &&
     (rx_byte[7:1] == GCALL_ADDR || rx_byte[7:1] != own_addr))
      |=> !ack_reg ##1 (st_reg == LS_SKIP))
    else $error("foreign or general call address acknowledged");

  a_nack_stop: assert property (@(posedge scl_clk_i) disable iff (link_hold_reg) // [RULE6]
    (st_reg == LS_RDATA && bit_cnt_reg == ACK_SLOT && sda_i) |=> (st_reg == LS_SKIP))
    else $error("read continued after host NACK");

endmodule

// *** tb/psic_host.sv ***
// Host model: drives the link clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module psic_host (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;       // Link clock stands still high
    sda_low_o = 1'b0;   // Data released
  end
  // START or repeated START, clock held high 0.6 us after
  task automatic start();
    sda_low_o = 1'b0;
    #31.25 scl_o = 1'b1;
    #100 sda_low_o = 1'b1;
    #600 scl_o = 1'b0;
    #31.25;
  endtask
  // STOP, then the clock stands still
  task automatic stop();
    sda_low_o = 1'b1;
    #31.25 scl_o = 1'b1;
    #100 sda_low_o = 1'b0;
    #200;
  endtask
  // Eight bits MSB first, then the acknowledge slot; 125 ns per clock
  task automatic xfer(input logic [7:0] w, input logic ack_drv, output logic [7:0] r, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_low_o = (i > 0) ? ~w[i-1] : ack_drv;
      #31.25 scl_o = 1'b1;
      #31.25 r[(i > 0) ? i - 1 : 0] = (i > 0) ? sda_i : r[0];
      ack = ~sda_i;
      #31.25 scl_o = 1'b0;
      #31.25;
    end
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench: registers reached over the serial link.
// Assumes psic_pkg, psic_top and psic_host compiled first.
`timescale 1ns/1ps
module testbench;
  import psic_pkg::*;
  logic       sys_clk, rst, btn, lowv;
  logic [3:0] temp;
  logic [2:0] sel;
  logic [1:0] dbsel;
  logic [14:0] oc;                                    // Fault sources: buck, boost, fuse, ldo
  logic [6:0] addr;                                   // Current target address
  wire logic  scl, host_low, sda_oe, sda_dev, irq_n, irq_oe;
  wire logic  sda = ~(host_low | (sda_oe & ~sda_dev)); // Pulled-up line
  int         mismatches, checked, cycles;
  psic_top #(.DBNC_MID_CYCLES(20), .DBNC_SLOW_CYCLES(40), .DBNC_FAULT_CYCLES(30)) i_dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .scl_clk_i(scl), .sda_i(sda), .sda_o(sda_dev), .sda_oe_o(sda_oe),
    .irq_out_n_o(irq_n), .irq_oe_o(irq_oe), .power_button_in_i(btn), .low_supply_in_i(lowv),
    .temp_level_in_i(temp), .buck_overcurrent_in_i(oc[6:0]), .boost_overcurrent_in_i(oc[7]),
    .fuse_memory_error_in_i(oc[8]), .ldo_overcurrent_in_i(oc[14:9]), .target_addr_select_bits_i(sel),
    .button_debounce_select_i(dbsel));
  psic_host i_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic [2:0] a;
    i_host.start();
    i_host.xfer({addr, 1'b0}, 1'b0, r, a[2]);
    i_host.xfer(idx, 1'b0, r, a[1]);
    i_host.xfer(d, 1'b0, r, a[0]);
    i_host.stop();
    chk({5'h00, a}, 8'h07);
  endtask
  // Two-byte read: host acks the first, nacks the second
  task automatic rd(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] r0, r1;
    logic [3:0] a;
    logic       n;
    i_host.start();
    i_host.xfer({addr, 1'b0}, 1'b0, r0, a[3]);
    i_host.xfer(idx, 1'b0, r0, a[2]);
    i_host.start();
    i_host.xfer({addr, 1'b1}, 1'b0, r0, a[1]);
    i_host.xfer(8'hFF, 1'b1, r0, a[0]);
    i_host.xfer(8'hFF, 1'b0, r1, n);
    chk({7'h00, sda_oe}, 8'h00);
    i_host.stop();
    chk({4'h0, a}, 8'h0F);
    chk(r0, e0);
    chk(r1, e1);
  endtask
  task automatic probe(input logic [6:0] a7, input logic e);
    logic [7:0] r;
    logic       a;
    i_host.start();
    i_host.xfer({a7, 1'b0}, 1'b0, r, a);
    i_host.stop();
    chk({7'h00, a}, {7'h00, e});
  endtask
  task automatic irq(input logic e);
    repeat (4) @(negedge sys_clk);
    chk({6'h00, irq_oe, irq_n}, {6'h00, ~e, e});
  endtask
  task automatic test_done();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst = 1'b1; btn = 1'b0; lowv = 1'b0; temp = 4'h0; sel = 3'h2; dbsel = 2'h0; addr = 7'h2A;
    mismatches = 0; checked = 0; cycles = 0;
    oc = 15'h0000;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (12) @(negedge sys_clk);
    irq(1'b1);
    rd(8'h05, 8'h00, 8'h3F);
    probe(7'h2B, 1'b0);
    probe(7'h00, 1'b0);
    $display("reset and address test done");
    wr(8'h06, 8'h3E);
    @(negedge sys_clk) btn = 1'b1;
    repeat (200) @(negedge sys_clk);
    irq(1'b0);
    rd(8'h07, 8'h01, 8'h00);
    @(negedge sys_clk) btn = 1'b0;
    repeat (200) @(negedge sys_clk);
    rd(8'h05, 8'h01, 8'h3E);
    wr(8'h05, 8'h00);
    irq(1'b0);
    wr(8'h05, 8'h01);
    irq(1'b1);
    $display("button test done");
    @(negedge sys_clk) temp = 4'h1;
    repeat (200) @(negedge sys_clk);
    irq(1'b1);
    rd(8'h05, 8'h04, 8'h3E);
    wr(8'h06, 8'h3A);
    irq(1'b0);
    wr(8'h06, 8'h3F);
    irq(1'b1);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h04, 8'h00);
    $display("thermal and mask test done");
    @(negedge sys_clk) sel = 3'h5;
    addr = 7'h2D;
    probe(7'h2A, 1'b0);
    wr(8'h05, 8'h04);
    rd(8'h05, 8'h00, 8'h3F);
    $display("address change test done");
    @(negedge sys_clk) dbsel = 2'h2;
    wr(8'h06, 8'h3D);
    @(negedge sys_clk) lowv = 1'b1;
    repeat (100) @(negedge sys_clk);
    irq(1'b1);
    lowv = 1'b0;
    repeat (50) @(negedge sys_clk);
    irq(1'b1);
    repeat (100) @(negedge sys_clk);
    irq(1'b0);
    wr(8'h05, 8'h02);
    irq(1'b1);
    @(negedge sys_clk) oc = 15'h0101;
    repeat (100) @(negedge sys_clk);
    oc = 15'h0000;
    repeat (100) @(negedge sys_clk);
    rd(8'h0E, 8'h80, 8'h81);
    rd(8'h08, 8'h01, 8'h7F);
    $display("supply and fault test done");
    test_done();
  end
endmodule
